// ===== usart_frame_consts.vh
// Constants for the serial port frame, mode and bit-rate configuration block.
// Behaviour
// - Multi-processor enable bit 1 turns multi-processor mode on, 0 turns it off.
// - Mode field selects asynchronous 0, synchronous 1, infrared 2, host SPI 3.
// - Mode 3 shows the host SPI frame layout; other modes show the normal one.
// - Parity field: 0 none, 2 even, 3 odd, 1 reserved.
// - Transmitter sends one stop bit for select 0, two for select 1.
// - Receiver checks frames the same way whatever the stop-bit select says.
// - Character size codes 0 to 3 select 5, 6, 7 or 8 data bits.
// - Code 6 is 9-bit low byte first, 7 high byte first; 4, 5 reserved.
// - Host SPI data order 0 shifts MSB first, 1 shifts LSB first.
// - Host SPI clock phase 0 samples on leading edge, 1 on trailing edge.
// - Divisor is 16 bits: low byte at base offset, high byte at base plus one.
// - Any divisor write reloads the prescaler at once.
// - Debug run 0 with processor halted: peripheral halts and ignores events.
// - Debug run 1: peripheral keeps running while the processor is halted.
`ifndef USART_FRAME_CONSTS_VH
`define USART_FRAME_CONSTS_VH

// Register indices; the byte address on the bus is four times the index.
`define IDX_RX_CONTROL        4'h6
`define IDX_FRAME_CONTROL     4'h7
`define IDX_DIVISOR_LOW       4'h8
`define IDX_DIVISOR_HIGH      4'h9
`define IDX_DEBUG_CONTROL     4'hb
`define IDX_STATUS            4'hc

// Reset values.
`define RST_FRAME_NORMAL      8'h03
`define RST_FRAME_SPI         8'h00
`define RST_DIVISOR           16'h0000
`define RST_DEBUG_CONTROL     8'h00

// Field positions.
`define POS_MULTIPROC         0
`define POS_RX_SPEED_LO       1
`define POS_RX_SPEED_HI       2
`define POS_MODE_LO           6
`define POS_MODE_HI           7
`define POS_PARITY_LO         4
`define POS_PARITY_HI         5
`define POS_STOP              3
`define POS_SIZE_LO           0
`define POS_SIZE_HI           2
`define POS_SPI_ORDER         2
`define POS_SPI_PHASE         1
`define POS_DEBUG_RUN         0

// Communication mode codes.
`define MODE_ASYNC            2'h0
`define MODE_SYNC             2'h1
`define MODE_INFRARED         2'h2
`define MODE_HOST_SPI         2'h3

// Parity codes.
`define PARITY_NONE           2'h0
`define PARITY_EVEN           2'h2
`define PARITY_ODD            2'h3

// Character size codes.
`define SIZE_5                3'h0
`define SIZE_6                3'h1
`define SIZE_7                3'h2
`define SIZE_8                3'h3
`define SIZE_9_LOW            3'h6
`define SIZE_9_HIGH           3'h7

`endif

// ===== bit_rate_prescaler.v
// Bit-rate prescaler: a down counter that pulses once per divisor plus one cycles.
module bit_rate_prescaler #(
    parameter WIDTH = 16
) (
    input  wire             clk,
    input  wire             rst_n,
    input  wire             reload,
    input  wire [WIDTH-1:0] divisor,
    input  wire             run,
    output reg              tick,
    output reg  [WIDTH-1:0] count
);

    // A reload wins over everything; a stopped counter keeps its value and emits no pulse.
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count <= {WIDTH{1'b0}};
            tick  <= 1'b0;
        end else if (reload) begin
            count <= divisor;
            tick  <= 1'b0;
        end else if (!run) begin
            tick <= 1'b0;
        end else if (count == {WIDTH{1'b0}}) begin
            count <= divisor;
            tick  <= 1'b1;
        end else begin
            count <= count - {{(WIDTH-1){1'b0}}, 1'b1};
            tick  <= 1'b0;
        end
    end

endmodule

// ===== usart_frame_mode_config.v
// Frame, mode, bit-rate and debug-halt configuration of the serial port, with a Wishbone slave.
//
// The Wishbone slave port was chosen for this implementation.
`include "usart_frame_consts.vh"

module usart_frame_mode_config #(
    parameter DIV_WIDTH = 16
) (
    input  wire                 sys_clk,
    input  wire                 nrst,
    input  wire                 wb_cyc_i,
    input  wire                 wb_stb_i,
    input  wire                 wb_we_i,
    input  wire [5:0]           wb_adr_i,
    input  wire [3:0]           wb_sel_i,
    input  wire [31:0]          wb_dat_i,
    output reg  [31:0]          wb_dat_o,
    output reg                  wb_ack_o,
    input  wire                 cpu_debug_halt,
    input  wire                 periph_event,
    output reg                  event_accepted,
    output reg                  periph_run,
    output reg  [1:0]           comm_mode_select,
    output reg                  async_mode,
    output reg                  sync_mode,
    output reg                  infrared_mode,
    output reg                  host_spi_mode,
    output reg                  multiproc_enable,
    output reg  [1:0]           receiver_speed_mode,
    output reg                  parity_enable,
    output reg                  parity_odd,
    output reg                  tx_two_stop_bits,
    output reg  [3:0]           data_bits,
    output reg                  nine_bit_low_first,
    output reg                  nine_bit_high_first,
    output reg                  spi_lsb_first,
    output reg                  spi_sample_trailing,
    output reg                  bit_rate_tick
);

    // Number of data bits for a character size code; reserved codes fall back to eight.
    function [3:0] char_bits;
        input [2:0] code;
        begin
            case (code)
                `SIZE_5:      char_bits = 4'h5;
                `SIZE_6:      char_bits = 4'h6;
                `SIZE_7:      char_bits = 4'h7;
                `SIZE_9_LOW:  char_bits = 4'h9;
                `SIZE_9_HIGH: char_bits = 4'h9;
                default:      char_bits = 4'h8;
            endcase
        end
    endfunction

    reg                 rst_meta;
    reg                 rst_n;
    reg                 halt_meta;
    reg                 halt_sync;
    reg                 event_meta;
    reg                 event_sync;

    reg  [1:0]          mode;
    reg  [1:0]          parity;
    reg                 stop_sel;
    reg  [2:0]          char_size;
    reg                 spi_order;
    reg                 spi_phase;
    reg                 mp_enable;
    reg  [1:0]          rx_speed;
    reg                 debug_run;
    reg  [15:0]         divisor;
    reg                 divisor_written;

    wire                bus_req;
    wire                bus_write;
    wire [3:0]          reg_idx;
    wire [7:0]          wbyte;
    wire                halted;
    wire                tick_raw;
    reg  [7:0]          next_rdata;
    reg  [7:0]          frame_view;

    // Reset is taken asynchronously and released through two flip-flops.
    always @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    // Debug halt and incoming events arrive from outside and pass two flip-flops.
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            halt_meta  <= 1'b0;
            halt_sync  <= 1'b0;
            event_meta <= 1'b0;
            event_sync <= 1'b0;
        end else begin
            halt_meta  <= cpu_debug_halt;
            halt_sync  <= halt_meta;
            event_meta <= periph_event;
            event_sync <= event_meta;
        end
    end

    // Bus decode: one aligned word per register, data in the low byte lane.
    assign bus_req   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign bus_write = bus_req & wb_we_i & wb_sel_i[0];
    assign reg_idx   = wb_adr_i[5:2];
    assign wbyte     = wb_dat_i[7:0];

    // The block halts only when the processor is halted and debug run is clear.
    assign halted = halt_sync & ~debug_run;

    // Register writes; the mode written decides which frame layout the byte fills.
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            mode            <= `MODE_ASYNC;
            parity          <= `PARITY_NONE;
            stop_sel        <= 1'b0;
            char_size       <= `SIZE_8;
            spi_order       <= 1'b0;
            spi_phase       <= 1'b0;
            mp_enable       <= 1'b0;
            rx_speed        <= 2'h0;
            debug_run       <= 1'b0;
            divisor         <= `RST_DIVISOR;
            divisor_written <= 1'b0;
        end else begin
            divisor_written <= 1'b0;
            if (bus_write) begin
                if (reg_idx == `IDX_RX_CONTROL) begin
                    mp_enable <= wbyte[`POS_MULTIPROC];
                    rx_speed  <= wbyte[`POS_RX_SPEED_HI:`POS_RX_SPEED_LO];
                end else if (reg_idx == `IDX_FRAME_CONTROL) begin
                    mode <= wbyte[`POS_MODE_HI:`POS_MODE_LO];
                    if (wbyte[`POS_MODE_HI:`POS_MODE_LO] == `MODE_HOST_SPI) begin
                        spi_order <= wbyte[`POS_SPI_ORDER];
                        spi_phase <= wbyte[`POS_SPI_PHASE];
                    end else begin
                        parity    <= wbyte[`POS_PARITY_HI:`POS_PARITY_LO];
                        stop_sel  <= wbyte[`POS_STOP];
                        char_size <= wbyte[`POS_SIZE_HI:`POS_SIZE_LO];
                    end
                end else if (reg_idx == `IDX_DIVISOR_LOW) begin
                    divisor[7:0]    <= wbyte;
                    divisor_written <= 1'b1;
                end else if (reg_idx == `IDX_DIVISOR_HIGH) begin
                    divisor[15:8]   <= wbyte;
                    divisor_written <= 1'b1;
                end else if (reg_idx == `IDX_DEBUG_CONTROL) begin
                    debug_run <= wbyte[`POS_DEBUG_RUN];
                end
            end
        end
    end

    // Frame control as software sees it: host SPI layout only while mode is 3.
    always @* begin
        if (mode == `MODE_HOST_SPI) begin
            frame_view = {mode, 3'h0, spi_order, spi_phase, 1'b0};
        end else begin
            frame_view = {mode, parity, stop_sel, char_size};
        end
    end

    // Read mux; unmapped addresses read as zero.
    always @* begin
        next_rdata = 8'h00;
        if (reg_idx == `IDX_RX_CONTROL) begin
            next_rdata = {5'h00, rx_speed, mp_enable};
        end else if (reg_idx == `IDX_FRAME_CONTROL) begin
            next_rdata = frame_view;
        end else if (reg_idx == `IDX_DIVISOR_LOW) begin
            next_rdata = divisor[7:0];
        end else if (reg_idx == `IDX_DIVISOR_HIGH) begin
            next_rdata = divisor[15:8];
        end else if (reg_idx == `IDX_DEBUG_CONTROL) begin
            next_rdata = {7'h00, debug_run};
        end else if (reg_idx == `IDX_STATUS) begin
            next_rdata = {5'h00, halt_sync, halted, bit_rate_tick};
        end
    end

    // Every request is acknowledged one cycle after it is seen; ack lasts one cycle.
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end else begin
            wb_ack_o <= bus_req;
            if (bus_req && !wb_we_i) begin
                wb_dat_o <= {24'h000000, next_rdata};
            end
        end
    end

    // The prescaler reloads on any divisor write and freezes while halted.
    bit_rate_prescaler #(
        .WIDTH   (DIV_WIDTH)
    ) u_prescaler (
        .clk     (sys_clk),
        .rst_n   (rst_n),
        .reload  (divisor_written),
        .divisor (divisor[DIV_WIDTH-1:0]),
        .run     (~halted),
        .tick    (tick_raw),
        .count   ()
    );

    // Decoded configuration towards the frame engines, all registered.
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            comm_mode_select    <= `MODE_ASYNC;
            async_mode          <= 1'b1;
            sync_mode           <= 1'b0;
            infrared_mode       <= 1'b0;
            host_spi_mode       <= 1'b0;
            multiproc_enable    <= 1'b0;
            receiver_speed_mode <= 2'h0;
            parity_enable       <= 1'b0;
            parity_odd          <= 1'b0;
            tx_two_stop_bits    <= 1'b0;
            data_bits           <= 4'h8;
            nine_bit_low_first  <= 1'b0;
            nine_bit_high_first <= 1'b0;
            spi_lsb_first       <= 1'b0;
            spi_sample_trailing <= 1'b0;
        end else begin
            comm_mode_select    <= mode;
            async_mode          <= (mode == `MODE_ASYNC);
            sync_mode           <= (mode == `MODE_SYNC);
            infrared_mode       <= (mode == `MODE_INFRARED);
            host_spi_mode       <= (mode == `MODE_HOST_SPI);
            multiproc_enable    <= mp_enable;
            receiver_speed_mode <= rx_speed;
            // Reserved parity code 1 is treated as no parity.
            parity_enable       <= (parity == `PARITY_EVEN) | (parity == `PARITY_ODD);
            parity_odd          <= (parity == `PARITY_ODD);
            // Only the transmitter gets the stop count; the receiver checks one stop bit.
            tx_two_stop_bits    <= stop_sel;
            data_bits           <= char_bits(char_size);
            nine_bit_low_first  <= (char_size == `SIZE_9_LOW);
            nine_bit_high_first <= (char_size == `SIZE_9_HIGH);
            spi_lsb_first       <= spi_order;
            spi_sample_trailing <= spi_phase;
        end
    end

    // Run enable, gated events and the bit-rate pulse.
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            periph_run     <= 1'b1;
            event_accepted <= 1'b0;
            bit_rate_tick  <= 1'b0;
        end else begin
            periph_run     <= ~halted;
            event_accepted <= event_sync & ~halted;
            bit_rate_tick  <= tick_raw;
        end
    end

endmodule

// ===== usart_frame_mode_config_asserts.sv
// Concurrent checks of the serial port configuration block, bound to its ports.
module usart_frame_mode_config_asserts (
    input wire        sys_clk,
    input wire        nrst,
    input wire        wb_cyc_i,
    input wire        wb_stb_i,
    input wire        wb_ack_o,
    input wire [31:0] wb_dat_o,
    input wire        periph_event,
    input wire        event_accepted,
    input wire        periph_run,
    input wire [1:0]  comm_mode_select,
    input wire        async_mode,
    input wire        sync_mode,
    input wire        infrared_mode,
    input wire        host_spi_mode,
    input wire        parity_enable,
    input wire        parity_odd,
    input wire [3:0]  data_bits,
    input wire        nine_bit_low_first,
    input wire        nine_bit_high_first,
    input wire        bit_rate_tick
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    // A fresh request is answered on the next edge by a single-cycle acknowledge.
    a_ack_next_cycle: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
        else $error("acknowledge late or too long");
    a_read_upper_zero: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
        else $error("read data above the byte not zero");
    a_mode_one_hot: assert property (
        {async_mode, sync_mode, infrared_mode, host_spi_mode} == (4'h8 >> comm_mode_select))
        else $error("mode decode disagrees with mode field");
    a_odd_needs_parity: assert property (parity_odd |-> parity_enable)
        else $error("odd parity without parity enabled");
    a_size_legal: assert property (data_bits >= 4'h5 && data_bits <= 4'h9)
        else $error("character size out of range");
    a_nine_bit_order: assert property (
        nine_bit_low_first || nine_bit_high_first |->
        data_bits == 4'h9 && !(nine_bit_low_first && nine_bit_high_first))
        else $error("nine-bit order without nine data bits");
    a_halt_no_tick: assert property (!periph_run && !$past(periph_run) |-> !bit_rate_tick)
        else $error("bit-rate tick while halted");
    a_halt_no_event: assert property (!periph_run && !$past(periph_run) |-> !event_accepted)
        else $error("event taken while halted");
    a_event_cause: assert property (event_accepted |-> $past(periph_event, 3))
        else $error("event taken without an incoming event");
    c_spi: cover property (host_spi_mode);
    c_nine_high: cover property (nine_bit_high_first);
    c_halted: cover property (!periph_run);
    c_event: cover property (event_accepted);
endmodule

bind usart_frame_mode_config usart_frame_mode_config_asserts i_chk (.*);

// ===== debug_event_source.sv
// Model of the debugger halt line and the event source beside the serial port.
module debug_event_source (
    input  wire logic sys_clk,
    input  wire logic halt_req,
    input  wire logic event_req,
    output logic      cpu_debug_halt = 1'b0,
    output logic      periph_event = 1'b0
);
    timeunit 1ns;
    timeprecision 1ps;
    // Both levels change just after a clock edge, as the processor core would drive them.
    always @(posedge sys_clk) begin
        cpu_debug_halt <= halt_req;
        periph_event   <= event_req;
    end
endmodule

// ===== tb.sv
// Self-checking bench for the serial port configuration block.
`include "usart_frame_consts.vh"
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin bad_count++; \
    $display("mismatch t=%0t got %h exp %h", $time, a, b); end end
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk = 0, nrst = 0, cyc = 0, we = 0, hreq = 0, ereq = 0, ack, halt, evt;
    logic [5:0] adr = 0;
    logic [3:0] sel = 0, nbits;
    logic [31:0] wdat = 0, rdat;
    logic [1:0] cm, rxs;
    logic as, sy, ir, sp, mp, pe, po, ts, nl, nh, lsb, trl, tick, evacc, run;
    logic [32:0] expq[$];
    logic [32:0] note;
    logic [7:0] f, s;
    logic [15:0] d;
    int bad_count = 0, check_count = 0, seed, n;

    usart_frame_mode_config #(.DIV_WIDTH(16)) i_dut (.sys_clk(sys_clk), .nrst(nrst),
        .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
        .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .cpu_debug_halt(halt),
        .periph_event(evt), .event_accepted(evacc), .periph_run(run), .comm_mode_select(cm),
        .async_mode(as), .sync_mode(sy), .infrared_mode(ir), .host_spi_mode(sp),
        .multiproc_enable(mp), .receiver_speed_mode(rxs), .parity_enable(pe), .parity_odd(po),
        .tx_two_stop_bits(ts), .data_bits(nbits), .nine_bit_low_first(nl),
        .nine_bit_high_first(nh), .spi_lsb_first(lsb), .spi_sample_trailing(trl),
        .bit_rate_tick(tick));
    debug_event_source i_dbg (.sys_clk(sys_clk), .halt_req(hreq), .event_req(ereq),
        .cpu_debug_halt(halt), .periph_event(evt));

    initial forever #5 sys_clk = ~sys_clk;

    // Each acknowledge retires the oldest note; read notes carry the expected byte.
    always @(posedge sys_clk) if (ack === 1'b1) begin
        note = expq.pop_front();
        if (note[32]) `CHK(rdat, note[31:0])
    end

    task automatic test_done();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    // One classic Wishbone cycle, held until the acknowledge is sampled.
    task automatic acc(input logic w, input logic [3:0] idx, input logic [7:0] v,
                       input logic chk, input logic [7:0] e, input logic [3:0] be = 4'h1);
        int k;
        expq.push_back({chk, 24'h0, e});
        @(posedge sys_clk);
        cyc <= 1; we <= w; adr <= {idx, 2'b00}; sel <= be; wdat <= {24'h0, v};
        k = 0;
        do begin @(posedge sys_clk); k++; end while (ack !== 1'b1 && k < 20);
        cyc <= 0;
        if (k >= 20) begin bad_count++; test_done(); end
    endtask

    // Counts edges up to the next bit-rate tick, bounded.
    task automatic wait_tick(output int m);
        m = 0;
        do begin @(posedge sys_clk); m++; end while (tick !== 1'b1 && m < 300);
        if (m >= 300) begin bad_count++; test_done(); end
    endtask

    function automatic logic [3:0] bits_of(input logic [2:0] c);
        return c < 3'h4 ? 4'h5 + c : (c < 3'h6 ? 4'h8 : 4'h9);
    endfunction

    initial begin
        seed = 61386;
        repeat (16) @(posedge sys_clk);
        nrst <= 1;
        repeat (4) @(posedge sys_clk);
        // Reset values, then an unmapped place that reads zero and ignores writes.
        acc(0, `IDX_FRAME_CONTROL, 8'h00, 1, `RST_FRAME_NORMAL);
        acc(0, `IDX_DIVISOR_HIGH, 8'h00, 1, 8'h00);
        acc(0, `IDX_DEBUG_CONTROL, 8'h00, 1, `RST_DEBUG_CONTROL);
        acc(1, 4'hf, 8'hff, 0, 8'h00);
        acc(0, 4'hf, 8'h00, 1, 8'h00);
        `CHK({as, nbits, run}, {1'b1, 4'h8, 1'b1})
        // Normal layout: modes, parity, stop and size codes, speed mode kept at zero.
        for (int i = 0; i < 8; i++) begin
            f = {2'(i % 3), i[1:0], i[0], i[2:0]};
            acc(1, `IDX_RX_CONTROL, {7'h0, i[0]}, 0, 8'h00);
            acc(1, `IDX_FRAME_CONTROL, f, 0, 8'h00);
            acc(0, `IDX_FRAME_CONTROL, 8'h00, 1, f);
            repeat (2) @(posedge sys_clk);
            `CHK({as, sy, ir, sp}, 4'h8 >> (i % 3))
            `CHK({cm, rxs}, {2'(i % 3), 2'h0})
            `CHK({pe, po}, {i[1], i[1] & i[0]})
            `CHK(ts, i[0])
            `CHK({nbits, nl, nh}, {bits_of(i[2:0]), i[2:0] == 3'h6, i[2:0] == 3'h7})
            `CHK(mp, i[0])
        end
        // A write without its byte lane leaves the register alone.
        acc(1, `IDX_FRAME_CONTROL, 8'h00, 0, 8'h00, 4'he);
        acc(0, `IDX_FRAME_CONTROL, 8'h00, 1, f);
        // Host SPI layout; order and phase read back, bits 5 to 3 and bit 0 read zero.
        for (int i = 0; i < 4; i++) begin
            acc(1, `IDX_FRAME_CONTROL, {2'h3, 3'($random(seed)), i[1:0], 1'b1}, 0, 8'h00);
            acc(0, `IDX_FRAME_CONTROL, 8'h00, 1, {5'h18, i[1:0], 1'b0});
            repeat (2) @(posedge sys_clk);
            `CHK({sp, lsb, trl}, {1'b1, i[1:0]})
        end
        acc(1, `IDX_FRAME_CONTROL, 8'h3f, 0, 8'h00);
        acc(0, `IDX_FRAME_CONTROL, 8'h00, 1, 8'h3f);
        // Divisor bytes, written while nothing is in flight.
        d = 16'($random(seed));
        acc(1, `IDX_DIVISOR_HIGH, d[15:8], 0, 8'h00);
        acc(1, `IDX_DIVISOR_LOW, d[7:0], 0, 8'h00);
        acc(0, `IDX_DIVISOR_HIGH, 8'h00, 1, d[15:8]);
        acc(0, `IDX_DIVISOR_LOW, 8'h00, 1, d[7:0]);
        s = 8'h03 + 8'($random(seed) & 15);
        // Low byte first, so the interim reload value is too large to tick before the last write.
        acc(1, `IDX_DIVISOR_LOW, s, 0, 8'h00);
        acc(1, `IDX_DIVISOR_HIGH, 8'h00, 0, 8'h00);
        wait_tick(n);
        `CHK(n, s + 3)
        wait_tick(n);
        `CHK(n, s + 1)
        // Debug halt with run bit clear: no ticks, no events; both return afterwards.
        ereq <= 1;
        repeat (6) @(posedge sys_clk);
        `CHK(evacc, 1'b1)
        hreq <= 1;
        repeat (6) @(posedge sys_clk);
        `CHK({run, evacc}, 2'b00)
        acc(0, `IDX_STATUS, 8'h00, 1, 8'h06);
        repeat (40) begin @(posedge sys_clk); `CHK(tick, 1'b0) end
        hreq <= 0;
        wait_tick(n);
        `CHK({run, evacc, n <= s + 8}, 3'b111)
        // Run bit set: the port keeps working while halted.
        acc(1, `IDX_DEBUG_CONTROL, 8'h01, 0, 8'h00);
        acc(0, `IDX_DEBUG_CONTROL, 8'h00, 1, 8'h01);
        hreq <= 1;
        repeat (6) @(posedge sys_clk);
        wait_tick(n);
        `CHK({run, evacc, n <= s + 1}, 3'b111)
        hreq <= 0;
        ereq <= 0;
        repeat (4) @(posedge sys_clk);
        test_done();
    end
endmodule
